// [rtl/copper_ctrl_pkg.sv]
// Package: register offsets, bit positions, reset values and types of the copper control block
package copper_ctrl_pkg;
    // Byte addresses on the register bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;       // copper_control, offset 0x0
    localparam logic [7:0] ADDR_AUX = 8'h04;        // second power-down, keep-alive, loopback speed
    localparam logic [7:0] ADDR_STATUS = 8'h08;     // applied state and activity flags
    // Bit positions in copper_control
    localparam int B_RESET = 15;
    localparam int B_LOOP = 14;
    localparam int B_SPD_LO = 13;
    localparam int B_ANEN = 12;
    localparam int B_PDOWN = 11;
    localparam int B_ISO = 10;
    localparam int B_RESTART = 9;
    localparam int B_DUPLEX = 8;
    localparam int B_SPD_HI = 6;
    // Bit positions in the auxiliary register
    localparam int A_PDOWN2 = 0;
    localparam int A_KEEP = 1;
    localparam int A_LSPD_LO = 2;                   // loopback speed, two bits
    // Hardware reset values
    localparam logic [15:0] CTRL_RST = 16'h1140;    // autoneg on, full duplex, 1000 Mbps
    localparam logic [3:0] AUX_RST = 4'hC;          // loopback speed field 2'b11, the reserved encoding, by default
    // Reset sequence length, in nanoseconds and in cycles at 200 MHz
    localparam int RESET_NS = 40;
    localparam int CLK_NS = 5;
    localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Speed encodings {high, low}
    typedef enum logic [1:0] {
        SPD_10 = 2'h0,
        SPD_100 = 2'h1,
        SPD_1000 = 2'h2,
        SPD_RSVD = 2'h3
    } speed_t;
    // Settings that take effect only on an update event
    typedef struct packed {
        logic [1:0] speed;
        logic an_enable;
        logic duplex;
    } applied_t;
endpackage

// [rtl/copper_control_upper_bits.sv]
// Copper control register bits 15..8 and 6 with AXI4-Lite access and applied PHY controls
`timescale 1ns/10ps
`default_nettype none
module copper_control_upper_bits
    import copper_ctrl_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Applied controls toward the PHY core
    output logic sm_reset,
    output logic an_restart,
    output logic an_active,
    output logic adv_only_1000t,
    output logic adv_1000t_full,
    output logic [1:0] speed_sel,
    output logic duplex_full,
    output logic loopback_en,
    output logic link_enable,
    output logic powered_down,
    output logic rgmii_enable,
    output logic mac_isolate
);

    // Elaboration check on the reset sequence length
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_chk
        $error("RESET_CYCLES must lie in 1..255");
    end

    // Register state
    logic [15:0] ctrl_q;          // software-visible copper_control
    logic [3:0] aux_q;            // second power-down, keep-alive, loopback speed
    applied_t app_q;              // settings in force
    logic [7:0] rst_cnt_q;        // reset sequence counter
    logic pd_q;                   // power-down state last cycle
    // AXI state
    logic aw_hold_q;
    logic w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Combined power-down request
    logic pd_now;
    logic pd_exit;
    logic aw_take;                // address handshake this cycle
    logic w_take;                 // data handshake this cycle
    logic wr_fire;
    logic wr_ctrl;
    logic [15:0] wr_val;
    logic sw_reset_req;
    logic restart_req;
    logic update_evt;
    logic rst_busy;

    // Merges byte-enabled write data into a 16-bit value
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = old;
        if (s[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (s[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    // Power down while either bit is one
    assign pd_now = ctrl_q[B_PDOWN] | aux_q[A_PDOWN2];
    assign pd_exit = pd_q & ~pd_now;
    // A half counts only after its own handshake, so no write fires twice
    assign aw_take = s_awvalid & s_awready;
    assign w_take = s_wvalid & s_wready;
    assign wr_fire = (aw_hold_q | aw_take) & (w_hold_q | w_take) & ~s_bvalid;
    assign wr_ctrl = wr_fire & ((aw_hold_q ? awaddr_q : s_awaddr) == ADDR_CTRL);
    assign wr_val = merge16(ctrl_q, w_hold_q ? wdata_q : s_wdata, w_hold_q ? wstrb_q : s_wstrb);
    // Software reset request: written bit, or leaving power down
    assign sw_reset_req = (wr_ctrl & wr_val[B_RESET]) | pd_exit;
    assign restart_req = (wr_ctrl & wr_val[B_RESTART]) | pd_exit;
    assign update_evt = sw_reset_req | restart_req;
    assign rst_busy = rst_cnt_q != 8'h00;

    // Write address and data capture, taken in either order
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (clk_en) begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end else begin
                // Latch whichever half arrives first
                if (s_awvalid && s_awready) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q <= s_awaddr;
                end
                if (s_wvalid && s_wready) begin
                    w_hold_q <= 1'b1;
                    wdata_q <= s_wdata;
                    wstrb_q <= s_wstrb;
                end
            end
        end
    end

    // Ready flags: accept a half while it is not already held
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
        end else if (clk_en) begin
            s_awready <= ~s_awready & ~aw_hold_q & ~s_bvalid & ~(s_awvalid & wr_fire);
            s_wready <= ~s_wready & ~w_hold_q & ~s_bvalid & ~(s_wvalid & wr_fire);
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_bvalid <= 1'b1;
                // Unmapped address answers with an error
                case (aw_hold_q ? awaddr_q : s_awaddr)
                    ADDR_CTRL, ADDR_AUX, ADDR_STATUS: s_bresp <= RESP_OKAY;
                    default: s_bresp <= RESP_SLVERR;
                endcase
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Copper control register bits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RST;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                // Bit 7 and bits 5..0 read as zero
                ctrl_q <= wr_val & 16'hFF40;
            end else begin
                // Self-clear once the reset sequence finishes
                if (rst_cnt_q == 8'h01) begin
                    ctrl_q[B_RESET] <= 1'b0;
                end
                // Restart self-clears once handed to the core
                if (an_restart) begin
                    ctrl_q[B_RESTART] <= 1'b0;
                end
                // Software reset clears loopback and isolate, keeps power down
                if (rst_cnt_q == 8'h01) begin
                    ctrl_q[B_LOOP] <= 1'b0;
                    ctrl_q[B_ISO] <= 1'b0;
                end
            end
        end
    end

    // Auxiliary register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aux_q <= AUX_RST;
        end else if (clk_en) begin
            if (wr_fire && (aw_hold_q ? awaddr_q : s_awaddr) == ADDR_AUX && (w_hold_q ? wstrb_q[0] : s_wstrb[0])) begin
                aux_q <= (w_hold_q ? wdata_q[3:0] : s_wdata[3:0]);
            end
        end
    end

    // Reset sequence counter, starts the same cycle the request is seen
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rst_cnt_q <= 8'h00;
        end else if (clk_en) begin
            if (sw_reset_req) begin
                rst_cnt_q <= 8'(RESET_CYCLES);
            end else if (rst_busy) begin
                rst_cnt_q <= rst_cnt_q - 8'h01;
            end
        end
    end

    // Pending speed, duplex and autoneg settings copied in on events
    always_ff @(posedge clk) begin
        if (!rstn) begin
            app_q <= '{speed: {CTRL_RST[B_SPD_HI], CTRL_RST[B_SPD_LO]}, an_enable: CTRL_RST[B_ANEN],
                       duplex: CTRL_RST[B_DUPLEX]};
            pd_q <= 1'b0;
        end else if (clk_en) begin
            pd_q <= pd_now;
            if (update_evt) begin
                app_q.speed <= {wr_ctrl ? wr_val[B_SPD_HI] : ctrl_q[B_SPD_HI],
                                wr_ctrl ? wr_val[B_SPD_LO] : ctrl_q[B_SPD_LO]};
                app_q.an_enable <= wr_ctrl ? wr_val[B_ANEN] : ctrl_q[B_ANEN];
                app_q.duplex <= wr_ctrl ? wr_val[B_DUPLEX] : ctrl_q[B_DUPLEX];
            end
        end
    end

    // Pulses and applied controls toward the core
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sm_reset <= 1'b1;
            an_restart <= 1'b0;
            an_active <= 1'b0;
            adv_only_1000t <= 1'b0;
            adv_1000t_full <= 1'b0;
            speed_sel <= SPD_1000;
            duplex_full <= 1'b1;
            loopback_en <= 1'b0;
            link_enable <= 1'b0;
            powered_down <= 1'b0;
            rgmii_enable <= 1'b1;
            mac_isolate <= 1'b0;
        end else if (clk_en) begin
            // State machines held in reset while the sequence runs
            sm_reset <= sw_reset_req | (rst_busy & rst_cnt_q != 8'h01);
            // Restart on bit write, on reset end, and after hardware reset
            an_restart <= (restart_req & ~sw_reset_req) | (rst_cnt_q == 8'h01) | sm_reset & ~rst_busy;
            // Forced 1000 keeps autoneg running, 1000T only
            an_active <= app_q.an_enable | (app_q.speed == SPD_1000);
            adv_only_1000t <= ~app_q.an_enable & (app_q.speed == SPD_1000);
            adv_1000t_full <= app_q.duplex;
            // Loopback speed replaces the normal select
            speed_sel <= ctrl_q[B_LOOP] ? aux_q[A_LSPD_LO+:2] : app_q.speed;
            duplex_full <= app_q.duplex;
            loopback_en <= ctrl_q[B_LOOP] & ~pd_now;
            link_enable <= ~ctrl_q[B_LOOP] & ~pd_now;
            powered_down <= pd_now;
            rgmii_enable <= ~pd_now | aux_q[A_KEEP];
            mac_isolate <= ctrl_q[B_ISO];
        end
    end

    // Read channel
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            s_arready <= ~s_arready & ~s_rvalid & s_arvalid;
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= RESP_OKAY;
                case (s_araddr)
                    ADDR_CTRL: s_rdata <= {16'h0000, ctrl_q};
                    ADDR_AUX: s_rdata <= {28'h0000000, aux_q};
                    ADDR_STATUS: s_rdata <= {24'h000000, rst_busy, pd_now, an_active, app_q.an_enable,
                                             app_q.duplex, app_q.speed, adv_only_1000t};
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Assertions
    a_reset_selfclr: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && rst_cnt_q == 8'h01 && !wr_ctrl |=> !ctrl_q[B_RESET])
        else $error("reset bit did not self-clear");
    a_reset_immed: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && wr_ctrl && wr_val[B_RESET] |=> sm_reset)
        else $error("reset did not start at once");
    a_reset_holds: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && sw_reset_req |=> rst_cnt_q == 8'(RESET_CYCLES))
        else $error("reset sequence length wrong");
    a_loop_link: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && ctrl_q[B_LOOP] |=> !link_enable)
        else $error("link kept in loopback");
    a_loop_speed: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && ctrl_q[B_LOOP] |=> speed_sel == $past(aux_q[A_LSPD_LO+:2]))
        else $error("loopback speed not used");
    a_speed_pend: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && !update_evt |=> app_q == $past(app_q))
        else $error("setting applied without event");
    a_forced_1000: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && !app_q.an_enable && app_q.speed == SPD_1000 |=> an_active && adv_only_1000t)
        else $error("forced 1000 without autoneg");
    a_pd_either: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && (ctrl_q[B_PDOWN] || aux_q[A_PDOWN2]) |=> powered_down)
        else $error("not powered down");
    a_pd_exit: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && pd_exit |=> sm_reset ##[1:300] an_restart)
        else $error("power-down exit without reset and restart");
    a_rgmii_keep: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && pd_now && !aux_q[A_KEEP] |=> !rgmii_enable)
        else $error("rgmii left on in power down");
    a_isolate: assert property (@(posedge clk) disable iff (!rstn)
        clk_en |=> mac_isolate == $past(ctrl_q[B_ISO]))
        else $error("isolate not followed");
    c_sw_reset: cover property (@(posedge clk) disable iff (!rstn) sw_reset_req ##[1:20] an_restart);
    c_pd_cycle: cover property (@(posedge clk) disable iff (!rstn) pd_now ##1 pd_exit);
    c_loopback: cover property (@(posedge clk) disable iff (!rstn) loopback_en);
    c_forced: cover property (@(posedge clk) disable iff (!rstn) adv_only_1000t);

endmodule // copper_control_upper_bits
`default_nettype wire

// [dv/mgmt_master.sv]
// Management station model: AXI4-Lite master with write and read tasks
`timescale 1ns/10ps
`default_nettype none
module mgmt_master (
    input wire logic clk,
    output logic [7:0] s_awaddr = 8'h00,
    output logic s_awvalid = 1'b0,
    input wire logic s_awready,
    output logic [31:0] s_wdata = 32'h0,
    output logic [3:0] s_wstrb = 4'h0,
    output logic s_wvalid = 1'b0,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    output logic s_bready = 1'b0,
    output logic [7:0] s_araddr = 8'h00,
    output logic s_arvalid = 1'b0,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid,
    output logic s_rready = 1'b0
);
    // Write: both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic fin;
        fin = 1'b0;
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hF;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!fin) begin
            @(posedge clk);
            // Released payload no longer shows the old value
            if (s_awvalid && s_awready) begin
                s_awvalid <= 1'b0;
                s_awaddr <= ~a;
            end
            if (s_wvalid && s_wready) begin
                s_wvalid <= 1'b0;
                s_wdata <= ~d;
            end
            if (s_bvalid === 1'b1 && s_bready) begin
                r = s_bresp;
                s_bready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask
    // Read: address held until taken, data taken with rvalid
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic fin;
        fin = 1'b0;
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!fin) begin
            @(posedge clk);
            if (s_arvalid && s_arready) begin
                s_arvalid <= 1'b0;
                s_araddr <= ~a;
            end
            if (s_rvalid === 1'b1 && s_rready) begin
                d = s_rdata;
                r = s_rresp;
                s_rready <= 1'b0;
                fin = 1'b1;
            end
        end
    endtask
endmodule // mgmt_master
`default_nettype wire

// [dv/copper_control_upper_bits_tb.sv]
// Testbench for the copper control upper bits
`timescale 1ns/10ps
`default_nettype none
module copper_control_upper_bits_tb;
    import copper_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1; // Running except while t_freeze holds it low
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, speed_sel;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic sm_reset, an_restart, an_active, adv_only_1000t, adv_1000t_full, duplex_full;
    logic loopback_en, link_enable, powered_down, rgmii_enable, mac_isolate;
    int err_total = 0;
    int tests_run = 0;
    int n_restart = 0; // Restart pulses seen
    int n_rst = 0; // Cycles with reset held
    int k, c;
    // Clock, 5 ns period
    always #2.5 clk = ~clk;
    // Pulse and level counters
    always @(posedge clk) begin
        if (an_restart === 1'b1) n_restart++;
        if (sm_reset === 1'b1) n_rst++;
    end
    copper_control_upper_bits dut (.clk, .rstn, .clk_en, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .sm_reset, .an_restart,
        .an_active, .adv_only_1000t, .adv_1000t_full, .speed_sel, .duplex_full, .loopback_en,
        .link_enable, .powered_down, .rgmii_enable, .mac_isolate);
    mgmt_master host (.clk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready);
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Write with okay response
    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    // Read and compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        chk("rdata", e, d);
    endtask
    // Let registered outputs land
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Bounded wait for reset to finish
    task automatic wait_low();
        for (int i = 0; i < 100 && sm_reset !== 1'b0; i++) @(posedge clk);
        #1;
    endtask
    task automatic t_hwreset();
        wait_low();
        settle();
        chk("hw restarts", 32'h1, n_restart);
        chk("speed", 32'h2, {30'h0, speed_sel});
        chk("an_active", 32'h1, {31'h0, an_active});
        rdc(ADDR_CTRL, 32'h1140);
        rdc(ADDR_AUX, 32'hC);
        $display("test hwreset done");
    endtask
    task automatic t_swreset();
        k = n_restart;
        c = n_rst;
        wrc(ADDR_CTRL, 32'h9140);
        #1;
        chk("sm_reset", 32'h1, {31'h0, sm_reset});
        wait_low();
        rdc(ADDR_CTRL, 32'h1140);
        chk("sw restarts", 32'h1, n_restart - k);
        chk("held", RESET_CYC, n_rst - c);
        $display("test swreset done");
    endtask
    task automatic t_speed();
        wrc(ADDR_CTRL, 32'h3100);
        settle();
        chk("pending", 32'h2, {30'h0, speed_sel});
        k = n_restart;
        wrc(ADDR_CTRL, 32'h3300);
        settle();
        chk("speed100", 32'h1, {30'h0, speed_sel});
        chk("restarts", 32'h1, n_restart - k);
        rdc(ADDR_CTRL, 32'h3100);
        wrc(ADDR_CTRL, 32'h1300);
        settle();
        chk("speed10", 32'h0, {30'h0, speed_sel});
        $display("test speed done");
    endtask
    task automatic t_forced();
        wrc(ADDR_CTRL, 32'h0240);
        settle();
        chk("an forced", 32'h1, {31'h0, an_active});
        chk("adv only", 32'h1, {31'h0, adv_only_1000t});
        chk("adv full", 32'h0, {31'h0, adv_1000t_full});
        chk("half duplex", 32'h0, {31'h0, duplex_full});
        wrc(ADDR_CTRL, 32'h2200);
        settle();
        chk("an off", 32'h0, {31'h0, an_active});
        chk("adv off", 32'h0, {31'h0, adv_only_1000t});
        wrc(ADDR_CTRL, 32'h1340);
        settle();
        chk("adv normal", 32'h0, {31'h0, adv_only_1000t});
        chk("adv full on", 32'h1, {31'h0, adv_1000t_full});
        chk("full duplex", 32'h1, {31'h0, duplex_full});
        $display("test forced done");
    endtask
    task automatic t_loop();
        wrc(ADDR_AUX, 32'h4);
        wrc(ADDR_CTRL, 32'h5140);
        settle();
        chk("loop", 32'h1, {31'h0, loopback_en});
        chk("link off", 32'h0, {31'h0, link_enable});
        chk("loop speed", 32'h1, {30'h0, speed_sel});
        wrc(ADDR_CTRL, 32'h1140);
        settle();
        chk("link on", 32'h1, {31'h0, link_enable});
        chk("speed back", 32'h2, {30'h0, speed_sel});
        $display("test loop done");
    endtask
    task automatic t_pdown();
        wrc(ADDR_CTRL, 32'h1940);
        settle();
        chk("down", 32'h1, {31'h0, powered_down});
        chk("rgmii off", 32'h0, {31'h0, rgmii_enable});
        wrc(ADDR_AUX, 32'h3);
        wrc(ADDR_CTRL, 32'h3100);
        settle();
        chk("down2", 32'h1, {31'h0, powered_down});
        chk("rgmii kept", 32'h1, {31'h0, rgmii_enable});
        k = n_restart;
        c = n_rst;
        wrc(ADDR_AUX, 32'h0);
        settle();
        wait_low();
        chk("up", 32'h0, {31'h0, powered_down});
        chk("exit restart", 32'h1, n_restart - k);
        chk("exit reset", RESET_CYC, n_rst - c);
        chk("exit speed", 32'h1, {30'h0, speed_sel});
        $display("test pdown done");
    endtask
    task automatic t_iso_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wrc(ADDR_CTRL, 32'h1540);
        settle();
        chk("isolate", 32'h1, {31'h0, mac_isolate});
        wrc(ADDR_CTRL, 32'h1140);
        settle();
        chk("no isolate", 32'h0, {31'h0, mac_isolate});
        host.rd(8'h0C, d, r);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        host.wr(8'h0C, 32'h0, r);
        chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        rdc(ADDR_STATUS, 32'h3A);
        $display("test isolate_unmapped done");
    endtask
    // Clock enable low freezes a running reset sequence
    task automatic t_freeze();
        c = n_rst;
        wrc(ADDR_CTRL, 32'h9140);
        clk_en <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk("frozen", 32'h1, {31'h0, sm_reset});
        @(posedge clk);
        clk_en <= 1'b1;
        wait_low();
        chk("stretched", 32'h1, {31'h0, (n_rst - c) > RESET_CYC});
        rdc(ADDR_CTRL, 32'h1140);
        $display("test freeze done");
    endtask
    // Verdict and end of run
    task automatic end_sim();
        $display("tests_run %0d err_total %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_hwreset();
        t_swreset();
        t_speed();
        t_forced();
        t_loop();
        t_pdown();
        t_iso_unmapped();
        t_freeze();
        end_sim();
    end
    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule // copper_control_upper_bits_tb
`default_nettype wire
